// [acx_freq_cfg.sv]
// Aux timing path and output clock frequency configuration with AXI4-Lite registers
// Function
// R01: Synth B alternate bit gives 6312kHz; software keeps its T1 bit and field zero.
// R02: Aux path has no phase build-out and no phase offset.
// R03: Aux path locks to an input, or to main path when lock-to-main is set.
// R04: Aux forward synthesizer runs off 204.8MHz master clock at eight selectable rates; the code decodes nine rates from ten mode codes.
// R05: Digital-feedback bit picks forward synth, else aux PLL output, as feedback source.
// R06: Feedback synthesizer makes the locking frequency whichever source is selected.
// R07: Aux-from-main feeds aux PLL from main low-rate synth; select code picks rate.
// R08: Aux PLL runs at 4x input; divided by 2,4,8,16,48,64 for outputs 1-7.
// R09: With aux-from-main, digital feedback must be set; aux low-rate synth uses forward synth.
// R10: Aux low-rate synth feeds 2k/8k when source bit set, and outputs 8,9 when selected.
// R11: With source bit clear, 2k/8k for outputs 1-7 come from main path.
// R12: Software clears aux-from-main for independent paths, sets it when locking is acceptable.
// R13: Each path yields one frequency family from its single PLL rate.
// R14: Main mode code selects 311.04MHz digital/analog or the five low-rate families.
// R15: Aux mode code selects squelched or normal 77.76MHz through 62.5MHz.
// R16: Output rate is PLL rate over the ratio; no /6 or /12 on aux families.
// R17: Software sets output selects after both PLL frequencies are configured.
// R18: Per-output 4-bit code selects off, 2k, 8k, synths, main or aux divisions.
// R19: Low-rate field picks E1 family rates, or T1 family when T1 bit set.
// R20: Reserved main and aux mode codes squelch the path rather than run undefined.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module acx_freq_cfg
  import acx_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [DATA_W-1:0]         s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]       s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic      [1:0]                s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic      [DATA_W-1:0]         s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output acx_main_cfg_t                  mainCfg_q,
  output acx_aux_cfg_t                   auxCfg_q,
  output acx_lr_rate_t                   synthARate_q,
  output acx_lr_rate_t                   synthBRate_q,
  output logic                           out89FromAux_q,
  output acx_route_t [OUT_CNT-1:0]       outRoute_q
);
  // Low-rate synth rate from T1 bit, field and alternate bit
  function automatic acx_lr_rate_t lrRate(input logic t1, input logic [1:0] f, input logic alt);
    if (alt)
      return LR_6312; // R01
    return acx_lr_rate_t'({1'b0, t1, f}); // R19
  endfunction

  function automatic acx_route_t decodeRoute(
    input logic [2:0] idx,
    input logic [3:0] code,
    input logic       lrAux,
    input logic       mainSq,
    input logic       auxSq);
    acx_route_t r;
    r.src = SRC_OFF;
    r.div = DIV_NONE;
    r.lowRateFromAux = 1'b0;
    r.squelch = 1'b0;
    // R18
    case (code)
      4'b0001: r.src = SRC_2K;
      4'b0010: r.src = SRC_8K;
      4'b0011:
      begin
        r.src = (idx == 3'd5) ? SRC_MAIN : SRC_SYNTH_B;
        r.div = (idx == 3'd5) ? DIV_2 : DIV_NONE;
      end
      4'b0100:
      begin
        r.src = (idx == 3'd6) ? SRC_MAIN : SRC_SYNTH_A;
        r.div = (idx == 3'd6) ? DIV_2 : DIV_NONE;
      end
      4'b0101:
      begin
        r.src = SRC_MAIN;
        r.div = (idx == 3'd5) ? DIV_1 : DIV_48;
      end
      4'b0110: {r.src, r.div} = {SRC_MAIN, DIV_16};
      4'b0111: {r.src, r.div} = {SRC_MAIN, DIV_12};
      4'b1000: {r.src, r.div} = {SRC_MAIN, DIV_8};
      4'b1001: {r.src, r.div} = {SRC_MAIN, DIV_6};
      4'b1010: {r.src, r.div} = {SRC_MAIN, DIV_4};
      4'b1011:
      begin
        // R08 Outputs 4 and 5 get /2 where the others get /64
        r.src = SRC_AUX;
        r.div = (idx == 3'd3 || idx == 3'd4) ? DIV_2 : DIV_64;
      end
      4'b1100: {r.src, r.div} = {SRC_AUX, DIV_48};
      4'b1101: {r.src, r.div} = {SRC_AUX, DIV_16};
      4'b1110: {r.src, r.div} = {SRC_AUX, DIV_8};
      4'b1111: {r.src, r.div} = {SRC_AUX, DIV_4};
      default: r.src = SRC_OFF;
    endcase
    if (r.src == SRC_2K || r.src == SRC_8K)
      r.lowRateFromAux = lrAux; // R10 R11
    r.squelch = (r.src == SRC_MAIN && mainSq) || (r.src == SRC_AUX && auxSq); // R16 R20
    return r;
  endfunction

  // Configuration registers
  logic [7:0] cfgFour_q;
  logic [7:0] cfgSix_q;
  logic [7:0] cfgSeven_q;
  logic [7:0] mainPath_q;
  logic [7:0] auxPath_q;
  logic [7:0] frameSync_q;

  // Bus state
  logic              awHeld_q;
  logic              wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [7:0]        wData_q;
  logic              wLane0_q;
  logic              bValid_q;
  logic [1:0]        bResp_q;
  logic              rdPend_q;
  logic [ADDR_W-1:0] arAddr_q;
  logic              rValid_q;
  logic [1:0]        rResp_q;
  logic [DATA_W-1:0] rData_q;

  // Bus decode
  wire logic doWrite  = ce && awHeld_q && wHeld_q && !bValid_q;
  wire logic arTake   = s_axi_arvalid && s_axi_arready && ce;
  wire logic wrIsSel  = awAddr_q >= OFS_OUTPUT_CFG_FIRST && awAddr_q <= OFS_OUTPUT_CFG_LAST;
  wire logic rdIsSel  = arAddr_q >= OFS_OUTPUT_CFG_FIRST && arAddr_q <= OFS_OUTPUT_CFG_LAST;
  wire logic wrAligned = awAddr_q[1:0] == 2'b00;
  wire logic rdAligned = arAddr_q[1:0] == 2'b00;
  wire logic wrMapped = wrAligned && (wrIsSel || awAddr_q <= OFS_FRAME_SYNC_CFG);
  wire logic rdMapped = rdAligned && (rdIsSel || arAddr_q <= OFS_STATUS);
  wire logic wrEnable = doWrite && wrMapped && wLane0_q;
  wire logic [ADDR_W-1:0] wrSelOfs = awAddr_q - OFS_OUTPUT_CFG_FIRST;
  wire logic [ADDR_W-1:0] rdSelOfs = s_axi_araddr - OFS_OUTPUT_CFG_FIRST;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rdPend_q && !rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rresp   = rResp_q;
  assign s_axi_rdata   = rData_q;

  // Output select words live in the small store
  logic [7:0]             selRdData;
  logic [SEL_WORDS*8-1:0] selWords;

  acx_out_sel_mem acx_out_sel_mem_inst (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .wrEn     (wrEnable && wrIsSel),
    .wrAddr   (wrSelOfs[3:2]),
    .wrData   (wData_q),
    .rdEn     (arTake),
    .rdAddr   (rdSelOfs[3:2]),
    .rdData_q (selRdData),
    .contents (selWords)
  );

  // Field extraction
  wire logic       lockToMain     = cfgFour_q[FLD_LOCK_TO_MAIN];
  wire logic       digFeedback    = cfgFour_q[FLD_DIG_FEEDBACK];
  wire logic       out89Aux       = cfgFour_q[FLD_OUT89_AUX];
  wire logic       synthAT1       = cfgSix_q[FLD_A_T1];
  wire logic       synthBT1       = cfgSix_q[FLD_B_T1];
  wire logic       synthBAlt      = cfgSix_q[FLD_B_ALT];
  wire logic [1:0] synthAFreq     = cfgSeven_q[FLD_A_FREQ +: 2];
  wire logic [1:0] synthBFreq     = cfgSeven_q[FLD_B_FREQ +: 2];
  wire logic [2:0] mainMode       = mainPath_q[FLD_MAIN_MODE +: 3];
  wire logic [2:0] toAuxSel       = mainPath_q[FLD_TO_AUX_SEL +: 3];
  wire logic       auxFromMain    = mainPath_q[FLD_AUX_FROM_MAIN]; // R12
  wire logic [3:0] auxMode        = auxPath_q[FLD_AUX_MODE +: 4];
  wire logic       lowRateSrc     = frameSync_q[FLD_LR_SRC];

  // Main path rate table
  acx_pll_rate_t mainRate;
  always_comb
  begin
    case (acx_main_mode_t'(mainMode)) // R14
      MAIN_77_DIG, MAIN_77_ANA: mainRate = PLL_311_040;
      MAIN_12E1:                mainRate = PLL_98_304;
      MAIN_16E1:                mainRate = PLL_131_072;
      MAIN_24DS1:               mainRate = PLL_148_224;
      MAIN_16DS1:               mainRate = PLL_98_816;
      MAIN_6312:                mainRate = PLL_100_992;
      default:                  mainRate = PLL_NONE; // R20
    endcase
  end

  // Aux path rate: its own forward synth, or main low-rate synth when steered
  acx_aux_mode_t fwdMode;
  acx_pll_rate_t auxRate;
  always_comb
  begin
    fwdMode = AUX_NONE;
    auxRate = PLL_NONE;
    if (auxFromMain)
    begin
      // R07 aux mode field ignored here
      case (toAuxSel)
        TOAUX_12E1:  auxRate = PLL_98_304;
        TOAUX_16E1:  auxRate = PLL_131_072;
        TOAUX_24DS1: auxRate = PLL_148_224;
        TOAUX_16DS1: auxRate = PLL_98_816;
        TOAUX_6312:  auxRate = PLL_100_992;
        default:     auxRate = PLL_NONE;
      endcase
    end
    else
    begin
      // R04 R15
      case (acx_aux_mode_t'(auxMode))
        AUX_77_SQ:  {fwdMode, auxRate} = {AUX_77_SQ, PLL_311_040};
        AUX_77:     {fwdMode, auxRate} = {AUX_77, PLL_311_040};
        AUX_12E1:   {fwdMode, auxRate} = {AUX_12E1, PLL_98_304};
        AUX_16E1:   {fwdMode, auxRate} = {AUX_16E1, PLL_131_072};
        AUX_24DS1:  {fwdMode, auxRate} = {AUX_24DS1, PLL_148_224};
        AUX_16DS1:  {fwdMode, auxRate} = {AUX_16DS1, PLL_98_816};
        AUX_2E3:    {fwdMode, auxRate} = {AUX_2E3, PLL_274_944};
        AUX_DS3:    {fwdMode, auxRate} = {AUX_DS3, PLL_178_944};
        AUX_6312:   {fwdMode, auxRate} = {AUX_6312, PLL_100_992};
        AUX_62M5:   {fwdMode, auxRate} = {AUX_62M5, PLL_250_000};
        default:    {fwdMode, auxRate} = {AUX_NONE, PLL_NONE}; // R20
      endcase
    end
  end

  wire logic mainSquelch = mainRate == PLL_NONE;
  wire logic auxSquelch  = auxRate == PLL_NONE || (!auxFromMain && auxMode == AUX_77_SQ);
  // Misprogramming is flagged, not corrected, so software sees what it wrote
  wire logic errAlt = synthBAlt && (synthBT1 || synthBFreq != 2'b00); // R01
  wire logic errFbk = auxFromMain && !digFeedback; // R09

  // Next values of the registered configuration outputs
  acx_aux_cfg_t                 auxCfg_d;
  acx_main_cfg_t                mainCfg_d;
  acx_route_t [OUT_CNT-1:0]     outRoute_d;
  always_comb
  begin
    mainCfg_d.analogFb = mainMode == MAIN_77_ANA;
    mainCfg_d.squelch  = mainSquelch;
    mainCfg_d.pllRate  = mainRate; // R13
    auxCfg_d.refFromMain = lockToMain; // R03
    auxCfg_d.fbkFromFwd  = digFeedback; // R05 R06
    auxCfg_d.pllFromMain = auxFromMain; // R07
    auxCfg_d.lfFromFwd   = auxFromMain; // R09
    auxCfg_d.squelch     = auxSquelch;
    auxCfg_d.fwdMode     = fwdMode;
    auxCfg_d.pllRate     = auxRate; // R08 R13
    for (int i = 0; i < OUT_CNT; i++)
      outRoute_d[i] = decodeRoute(3'(i), selWords[i*SEL_W +: SEL_W],
                                  lowRateSrc, mainSquelch, auxSquelch);
  end

  // Status word
  logic [DATA_W-1:0] statusWord;
  always_comb
  begin
    statusWord = '0;
    statusWord[FLD_ST_MAIN_RATE +: 4] = mainRate;
    statusWord[FLD_ST_AUX_RATE +: 4]  = auxRate;
    statusWord[FLD_ST_MAIN_SQ]        = mainSquelch;
    statusWord[FLD_ST_AUX_SQ]         = auxSquelch;
    statusWord[FLD_ST_ERR_ALT]        = errAlt;
    statusWord[FLD_ST_ERR_FBK]        = errFbk;
  end

  // Read mux, one cycle after the address is taken so the store's data is ready
  logic [7:0] rdByte;
  assign rdByte = (arAddr_q == OFS_MASTER_CFG_FOUR)  ? cfgFour_q   :
                  (arAddr_q == OFS_MASTER_CFG_SIX)   ? cfgSix_q    :
                  (arAddr_q == OFS_MASTER_CFG_SEVEN) ? cfgSeven_q  :
                  (arAddr_q == OFS_MAIN_PATH_CFG)    ? mainPath_q  :
                  (arAddr_q == OFS_AUX_PATH_CFG)     ? auxPath_q   :
                  (arAddr_q == OFS_FRAME_SYNC_CFG)   ? frameSync_q :
                  rdIsSel                            ? selRdData   : 8'h00;
  wire logic [DATA_W-1:0] rdWord = (arAddr_q == OFS_STATUS) ? statusWord :
                                   {{(DATA_W-8){1'b0}}, rdByte};

  // Write channel capture and response
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= RST_CFG;
      wLane0_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q  <= 1'b1;
        wData_q  <= s_axi_wdata[7:0];
        wLane0_q <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bValid_q && s_axi_bready)
        bValid_q <= 1'b0;
    end
  end

  // Register file writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfgFour_q   <= RST_CFG;
      cfgSix_q    <= RST_CFG;
      cfgSeven_q  <= RST_CFG;
      mainPath_q  <= RST_CFG;
      auxPath_q   <= RST_CFG;
      frameSync_q <= RST_CFG;
    end
    else if (ce && wrEnable)
    begin
      if (awAddr_q == OFS_MASTER_CFG_FOUR)
        cfgFour_q <= wData_q & 8'h07;
      else if (awAddr_q == OFS_MASTER_CFG_SIX)
        cfgSix_q <= wData_q & 8'h07;
      else if (awAddr_q == OFS_MASTER_CFG_SEVEN)
        cfgSeven_q <= wData_q & 8'h0f;
      else if (awAddr_q == OFS_MAIN_PATH_CFG)
        mainPath_q <= wData_q & 8'h7f;
      else if (awAddr_q == OFS_AUX_PATH_CFG)
        auxPath_q <= wData_q & 8'h0f;
      else if (awAddr_q == OFS_FRAME_SYNC_CFG)
        frameSync_q <= wData_q & 8'h01;
    end
  end

  // Read channel
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdPend_q <= 1'b0;
      arAddr_q <= '0;
      rValid_q <= 1'b0;
      rResp_q  <= RESP_OKAY;
      rData_q  <= '0;
    end
    else if (ce)
    begin
      if (arTake)
      begin
        rdPend_q <= 1'b1;
        arAddr_q <= s_axi_araddr;
      end
      else if (rdPend_q)
      begin
        rdPend_q <= 1'b0;
        rValid_q <= 1'b1;
        rData_q  <= rdMapped ? rdWord : '0;
        rResp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rValid_q && s_axi_rready)
        rValid_q <= 1'b0;
    end
  end

  // Registered configuration outputs; the aux path has no phase offset output at all
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mainCfg_q      <= '0;
      auxCfg_q       <= '0;
      // All-zero aux mode is the squelched one, so reset must show squelch too
      auxCfg_q.squelch <= 1'b1;
      synthARate_q   <= LR_2048;
      synthBRate_q   <= LR_2048;
      out89FromAux_q <= 1'b0;
      outRoute_q     <= '0;
    end
    else if (ce)
    begin
      mainCfg_q      <= mainCfg_d; // R02
      auxCfg_q       <= auxCfg_d;
      synthARate_q   <= lrRate(synthAT1, synthAFreq, 1'b0);
      synthBRate_q   <= lrRate(synthBT1, synthBFreq, synthBAlt);
      out89FromAux_q <= out89Aux; // R10
      outRoute_q     <= outRoute_d;
    end
  end
endmodule // acx_freq_cfg
`default_nettype wire

// [acx_freq_cfg_chk.sv]
// Port-level assertions for the frequency configuration block
`timescale 1ns/10ps
`default_nettype none
module acx_freq_cfg_chk
  import acx_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [DATA_W-1:0]        s_axi_rdata,
  input wire acx_main_cfg_t            mainCfg_q,
  input wire acx_aux_cfg_t             auxCfg_q,
  input wire acx_route_t [OUT_CNT-1:0] outRoute_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $past(sys_rst) |-> auxCfg_q.squelch && outRoute_q[0].src == SRC_OFF; endproperty
  a_rst: assert property (p_rst) else $error("reset config wrong");
  property p_msq; mainCfg_q.squelch == (mainCfg_q.pllRate == PLL_NONE); endproperty
  a_msq: assert property (p_msq) else $error("main squelch wrong");
  property p_asq; auxCfg_q.pllRate == PLL_NONE |-> auxCfg_q.squelch; endproperty
  a_asq: assert property (p_asq) else $error("aux squelch wrong");
  property p_a0; !auxCfg_q.pllFromMain && auxCfg_q.fwdMode == AUX_77_SQ |->
    auxCfg_q.squelch && auxCfg_q.pllRate == PLL_311_040; endproperty
  a_a0: assert property (p_a0) else $error("aux code zero wrong");
  property p_lf; auxCfg_q.lfFromFwd == auxCfg_q.pllFromMain; endproperty
  a_lf: assert property (p_lf) else $error("low rate source wrong");
  property p_pfm; auxCfg_q.pllFromMain |-> auxCfg_q.pllRate inside
    {PLL_98_304, PLL_131_072, PLL_148_224, PLL_98_816, PLL_100_992, PLL_NONE}; endproperty
  a_pfm: assert property (p_pfm) else $error("aux from main rate");
  property p_div; outRoute_q[0].src == SRC_AUX |->
    !(outRoute_q[0].div inside {DIV_1, DIV_6, DIV_12}); endproperty
  a_div: assert property (p_div) else $error("aux divider wrong");
  property p_bv; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bv: assert property (p_bv) else $error("bvalid dropped");
  property p_rv; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rv: assert property (p_rv) else $error("read data dropped");
endmodule // acx_freq_cfg_chk
bind acx_freq_cfg acx_freq_cfg_chk acx_freq_cfg_chk_inst (.clk, .sys_rst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mainCfg_q, .auxCfg_q, .outRoute_q);
`default_nettype wire

// [acx_out_sel_mem.sv]
// Small store for the per-output frequency select words, registered read port
`timescale 1ns/10ps
`default_nettype none
module acx_out_sel_mem
  import acx_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         ce,
  input  wire logic                         wrEn,
  input  wire logic [1:0]                   wrAddr,
  input  wire logic [7:0]                   wrData,
  input  wire logic                         rdEn,
  input  wire logic [1:0]                   rdAddr,
  output logic      [7:0]                   rdData_q,
  output logic      [SEL_WORDS*8-1:0]       contents
);
  logic [7:0] mem_q [SEL_WORDS];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < SEL_WORDS; i++)
        mem_q[i] <= RST_CFG;
      rdData_q <= RST_CFG;
    end
    else if (ce)
    begin
      if (wrEn)
        mem_q[wrAddr] <= wrData;
      if (rdEn)
        rdData_q <= mem_q[rdAddr];
    end
  end

  always_comb
  begin
    for (int i = 0; i < SEL_WORDS; i++)
      contents[i*8 +: 8] = mem_q[i];
  end
endmodule // acx_out_sel_mem
`default_nettype wire

// [acx_pkg.sv]
// Shared constants, encodings and carrier types for the aux path frequency configuration block
`default_nettype none
package acx_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned OUT_CNT  = 7;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned SEL_WORDS = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MASTER_CFG_FOUR  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASTER_CFG_SIX   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASTER_CFG_SEVEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MAIN_PATH_CFG    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_AUX_PATH_CFG     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FRAME_SYNC_CFG   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_CFG_FIRST = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_CFG_LAST  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS           = 8'h28;

  // Field positions
  localparam int unsigned FLD_LOCK_TO_MAIN  = 0;
  localparam int unsigned FLD_DIG_FEEDBACK  = 1;
  localparam int unsigned FLD_OUT89_AUX     = 2;
  localparam int unsigned FLD_A_T1          = 0;
  localparam int unsigned FLD_B_T1          = 1;
  localparam int unsigned FLD_B_ALT         = 2;
  localparam int unsigned FLD_A_FREQ        = 0;
  localparam int unsigned FLD_B_FREQ        = 2;
  localparam int unsigned FLD_MAIN_MODE     = 0;
  localparam int unsigned FLD_TO_AUX_SEL    = 3;
  localparam int unsigned FLD_AUX_FROM_MAIN = 6;
  localparam int unsigned FLD_AUX_MODE      = 0;
  localparam int unsigned FLD_LR_SRC        = 0;
  localparam int unsigned FLD_ST_MAIN_RATE  = 0;
  localparam int unsigned FLD_ST_AUX_RATE   = 4;
  localparam int unsigned FLD_ST_MAIN_SQ    = 8;
  localparam int unsigned FLD_ST_AUX_SQ     = 9;
  localparam int unsigned FLD_ST_ERR_ALT    = 10;
  localparam int unsigned FLD_ST_ERR_FBK    = 11;

  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // PLL frequencies in kHz by code name
  typedef enum logic [3:0] {
    PLL_311_040 = 4'b0000,
    PLL_98_304  = 4'b0001,
    PLL_131_072 = 4'b0010,
    PLL_148_224 = 4'b0011,
    PLL_98_816  = 4'b0100,
    PLL_274_944 = 4'b0101,
    PLL_178_944 = 4'b0110,
    PLL_100_992 = 4'b0111,
    PLL_250_000 = 4'b1000,
    PLL_NONE    = 4'b1111
  } acx_pll_rate_t;

  typedef enum logic [2:0] {
    MAIN_77_DIG = 3'b000,
    MAIN_77_ANA = 3'b001,
    MAIN_12E1   = 3'b010,
    MAIN_16E1   = 3'b011,
    MAIN_24DS1  = 3'b100,
    MAIN_16DS1  = 3'b101,
    MAIN_6312   = 3'b110,
    MAIN_RSVD   = 3'b111
  } acx_main_mode_t;

  typedef enum logic [3:0] {
    AUX_77_SQ  = 4'b0000,
    AUX_77     = 4'b0001,
    AUX_12E1   = 4'b0010,
    AUX_16E1   = 4'b0011,
    AUX_24DS1  = 4'b0100,
    AUX_16DS1  = 4'b0101,
    AUX_2E3    = 4'b0110,
    AUX_DS3    = 4'b0111,
    AUX_6312   = 4'b1000,
    AUX_62M5   = 4'b1001,
    AUX_NONE   = 4'b1111
  } acx_aux_mode_t;

  typedef enum logic [2:0] {
    TOAUX_12E1  = 3'b000,
    TOAUX_16E1  = 3'b010,
    TOAUX_24DS1 = 3'b100,
    TOAUX_16DS1 = 3'b110,
    TOAUX_6312  = 3'b111
  } acx_to_aux_t;

  typedef enum logic [3:0] {
    LR_2048  = 4'b0000,
    LR_4096  = 4'b0001,
    LR_8192  = 4'b0010,
    LR_16384 = 4'b0011,
    LR_1544  = 4'b0100,
    LR_3088  = 4'b0101,
    LR_6176  = 4'b0110,
    LR_12352 = 4'b0111,
    LR_6312  = 4'b1000
  } acx_lr_rate_t;

  typedef enum logic [2:0] {
    SRC_OFF     = 3'b000,
    SRC_2K      = 3'b001,
    SRC_8K      = 3'b010,
    SRC_SYNTH_B = 3'b011,
    SRC_SYNTH_A = 3'b100,
    SRC_MAIN    = 3'b101,
    SRC_AUX     = 3'b110
  } acx_src_t;

  typedef enum logic [3:0] {
    DIV_1    = 4'b0000,
    DIV_2    = 4'b0001,
    DIV_4    = 4'b0010,
    DIV_6    = 4'b0011,
    DIV_8    = 4'b0100,
    DIV_12   = 4'b0101,
    DIV_16   = 4'b0110,
    DIV_48   = 4'b0111,
    DIV_64   = 4'b1000,
    DIV_NONE = 4'b1111
  } acx_div_t;

  typedef struct packed {
    acx_src_t src;
    acx_div_t div;
    logic     lowRateFromAux;
    logic     squelch;
  } acx_route_t;

  typedef struct packed {
    logic          refFromMain;
    logic          fbkFromFwd;
    logic          pllFromMain;
    logic          lfFromFwd;
    logic          squelch;
    acx_aux_mode_t fwdMode;
    acx_pll_rate_t pllRate;
  } acx_aux_cfg_t;

  typedef struct packed {
    logic          analogFb;
    logic          squelch;
    acx_pll_rate_t pllRate;
  } acx_main_cfg_t;
endpackage
`default_nettype wire

// [test_acx_freq_cfg.sv]
// Self-checking bench for the frequency configuration block
`timescale 1ns/10ps
`default_nettype none
module test_acx_freq_cfg
  import acx_pkg::*;
;
  logic clk = 0, sys_rst = 1, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, out89FromAux_q;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  acx_main_cfg_t mainCfg_q;
  acx_aux_cfg_t auxCfg_q;
  acx_lr_rate_t synthARate_q, synthBRate_q;
  acx_route_t [OUT_CNT-1:0] outRoute_q;
  int numErrors = 0, nTests = 0;
  always #10 clk = ~clk;
  acx_freq_cfg acx_freq_cfg_inst (.clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mainCfg_q, .auxCfg_q, .synthARate_q,
    .synthBRate_q, .out89FromAux_q, .outRoute_q);
  task chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e)
    begin
      numErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task close_out;
    if (numErrors == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Ready is sampled before it drops, so each channel lets go on its own handshake
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
    repeat (2) @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] r = RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk(s_axi_rresp, r);
  endtask
  task t_modes;
    chk(mainCfg_q, 0);
    rd(8'h28);
    chk(d, 32'h200);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0c, i);
      chk(mainCfg_q.pllRate, 32'hf7432100 >> 4 * i & 15);
      chk(mainCfg_q.analogFb, i == 1);
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h10, i);
      chk(auxCfg_q.pllRate, 64'hffffff8765432100 >> 4 * i & 15);
      chk(auxCfg_q.squelch, i == 0 || i > 9);
    end
  endtask
  task t_synth;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h04, i > 3 ? 3 : 0);
      wr(8'h08, i % 4 * 5);
      chk(synthARate_q, i);
      chk(synthBRate_q, i);
    end
    wr(8'h04, 4);
    wr(8'h08, 0);
    chk(synthBRate_q, LR_6312);
    wr(8'h04, 6);
    rd(8'h28);
    chk(d[10], 1);
  endtask
  task t_tomain;
    wr(8'h00, 0);
    chk(auxCfg_q.fbkFromFwd, 0);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h0c, 8'h40 | s << 3);
      chk(auxCfg_q.pllRate, 32'h74f3f2f1 >> 4 * s & 15);
      chk(auxCfg_q.lfFromFwd, 1);
    end
    rd(8'h28);
    chk(d[11], 1);
    wr(8'h00, 3);
    chk({auxCfg_q.refFromMain, auxCfg_q.fbkFromFwd}, 3);
    rd(8'h28);
    chk(d[11], 0);
  endtask
  task t_route;
    wr(8'h14, 0);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h18, c);
      chk(outRoute_q[0].src, c < 5 ? c : (c < 11 ? 5 : 6));
      if (c > 4) chk(outRoute_q[0].div, 64'h2467823456700000 >> 4 * c & 15);
      if (c == 1) chk(outRoute_q[0].lowRateFromAux, 0);
    end
    wr(8'h14, 1);
    wr(8'h18, 2);
    chk(outRoute_q[0].lowRateFromAux, 1);
    wr(8'h1c, 8'hb0);
    chk(outRoute_q[3].div, DIV_2);
    wr(8'h00, 4);
    chk(out89FromAux_q, 1);
    rd(8'h2c, RESP_SLVERR);
    chk(d, 0);
    wr(8'h28, 1, RESP_SLVERR);
    wr(8'h10, 32'hff);
    rd(8'h10);
    chk(d, 32'hf);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    t_modes;
    t_synth;
    t_tomain;
    t_route;
    close_out;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    numErrors++;
    close_out;
  end
endmodule // test_acx_freq_cfg
`default_nettype wire
